// >>> common/cpu_regs_defs.vh
`ifndef CPU_REGS_DEFS_VH
`define CPU_REGS_DEFS_VH

// APB byte offsets of the dedicated registers.
`define OFS_PROGRAM_COUNTER 8'h00
`define OFS_ACCUMULATOR     8'h04
`define OFS_TEMP_ACC        8'h08
`define OFS_INDEX_REGISTER  8'h0C
`define OFS_EXTRA_POINTER   8'h10
`define OFS_STACK_POINTER   8'h14
`define OFS_PROGRAM_STATUS  8'h18
`define OFS_PROGRAM_BASE    8'h1C
`define OFS_REGION_STATUS   8'h20

// Reset values.
`define RST_PROGRAM_COUNTER 16'hFFFD
`define RST_ZERO16          16'h0000
`define RST_CCR             8'h0C
`define RST_RP              8'h00
`define RST_PRDATA          32'h0000_0000

// Field positions inside the condition code byte.
`define CCR_IRQ_ENABLE_BIT  4
`define CCR_LEVEL_HI        3
`define CCR_LEVEL_LO        2

// Address space layout defaults.
`define IO_LAST_DEFAULT     16'h007F
`define DATA_LAST_DEFAULT   16'h027F
`define PROG_BASE_DEFAULT   16'h8000

// Region codes in the region status word.
`define REGION_IO           4'h1
`define REGION_DATA         4'h2
`define REGION_PROGRAM      4'h4
`define REGION_NONE         4'h8

`endif

// >>> src/cpu_dedicated_registers.v
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/1ns
// Overview of operation
// RQ1: Program counter is a 16-bit register addressing the fetched instruction.
// RQ2: 16-bit accumulator; 8-bit instructions use and update only its low byte.
// RQ3: 16-bit temporary accumulator is second operand; 8-bit uses low byte.
// RQ4: 16-bit index register modifies operand addresses in indexed mode.
// RQ5: 16-bit extra pointer usable directly as a memory address.
// RQ6: 16-bit stack pointer locates the current stack position.
// RQ7: 16-bit program status holds bank pointer and condition flags.
// RQ8: Status upper byte is bank pointer, lower byte is condition code.
// RQ9: Reset sets counter to FFFD, clears interrupt enable, level to 11.
// RQ10: Decode 64K space: I/O lowest, data above it, program highest.
// RQ11: Software keeps vector tables at the top of the program area.
// RQ12: Bank pointer and condition code bytes update independently.
`include "cpu_regs_defs.vh"

module cpu_dedicated_registers #(
  parameter [15:0] IO_LAST   = `IO_LAST_DEFAULT,
  parameter [15:0] DATA_LAST = `DATA_LAST_DEFAULT,
  parameter [15:0] PROG_BASE = `PROG_BASE_DEFAULT
) (
  // Clock and reset.
  input  wire        pclk,
  input  wire        presetn,
  // APB slave.
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // Execution logic writes.
  input  wire        core_op8,
  input  wire        core_pc_we,
  input  wire [15:0] core_pc_d,
  input  wire        core_acc_we,
  input  wire [15:0] core_acc_d,
  input  wire        core_tmp_we,
  input  wire [15:0] core_tmp_d,
  input  wire        core_ix_we,
  input  wire [15:0] core_ix_d,
  input  wire        core_ep_we,
  input  wire [15:0] core_ep_d,
  input  wire        core_sp_we,
  input  wire [15:0] core_sp_d,
  input  wire        core_rp_we,
  input  wire [7:0]  core_rp_d,
  input  wire        core_ccr_we,
  input  wire [7:0]  core_ccr_d,
  // Register values toward the execution logic.
  output reg  [15:0] program_counter,
  output reg  [15:0] accumulator,
  output reg  [15:0] temp_accumulator,
  output reg  [15:0] index_register,
  output reg  [15:0] extra_pointer,
  output reg  [15:0] stack_pointer,
  output wire [15:0] program_status,
  output wire [7:0]  register_bank_pointer,
  output wire [7:0]  condition_code_byte,
  output wire        irq_enable,
  output wire [1:0]  interrupt_level,
  output wire [15:0] acc_operand,
  output wire [15:0] tmp_operand,
  // Address decode.
  input  wire [15:0] core_addr,
  output wire        sel_io,
  output wire        sel_data,
  output wire        sel_program,
  output wire        sel_none
);

  ////////////////////////////////////////////////////////////////////////////

  reg  [7:0]  rp_byte;
  reg  [7:0]  ccr_byte;
  reg  [15:0] prog_base;
  reg  [3:0]  region;
  reg  [31:0] next_prdata;
  reg         hit;

  // Decoded phases of the APB transfer.
  wire        setup   = psel & ~penable;
  wire        wr_acc  = psel & penable & pwrite;
  wire        rd_setup = setup & ~pwrite;

  // A narrow write keeps the upper byte, so 16-bit results survive 8-bit
  // arithmetic on the same register.
  function [15:0] merge16;
    input [15:0] old_v;
    input [15:0] new_v;
    input        op8;
    begin
      merge16 = op8 ? {old_v[15:8], new_v[7:0]} : new_v;
    end
  endfunction

  // Apply APB byte strobes to a 16-bit register.
  function [15:0] strobe16;
    input [15:0] old_v;
    input [31:0] wd;
    input [3:0]  st;
    begin
      strobe16 = {st[1] ? wd[15:8] : old_v[15:8],
                  st[0] ? wd[7:0]  : old_v[7:0]};
    end
  endfunction

  // Offset compare shared by every write decode; the read mux uses its own case.
  function is_ofs;
    input [7:0] a;
    input [7:0] ofs;
    begin
      is_ofs = (a == ofs);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // APB answers in the access cycle; read data was caught at setup.

  assign pready  = 1'b1;
  // An unmapped offset is refused in the access phase; a write to it is
  // dropped and a read of it returns zero.
  assign pslverr = psel & penable & ~hit;

  // Unused upper bits of the read word stay zero, so software may read a
  // 16-bit register as a plain word.
  always @* begin
    hit = 1'b1;
    next_prdata = 32'h0000_0000;
    case (paddr)
      `OFS_PROGRAM_COUNTER: next_prdata[15:0] = program_counter;
      `OFS_ACCUMULATOR:     next_prdata[15:0] = accumulator;
      `OFS_TEMP_ACC:        next_prdata[15:0] = temp_accumulator;
      `OFS_INDEX_REGISTER:  next_prdata[15:0] = index_register;
      `OFS_EXTRA_POINTER:   next_prdata[15:0] = extra_pointer;
      `OFS_STACK_POINTER:   next_prdata[15:0] = stack_pointer;
      `OFS_PROGRAM_STATUS:  next_prdata[15:0] = program_status;
      `OFS_PROGRAM_BASE:    next_prdata[15:0] = prog_base;
      `OFS_REGION_STATUS:   next_prdata[3:0]  = region;
      default:              hit = 1'b0;
    endcase
  end

  // Capturing read data at the setup edge lets pready stay high, so every
  // transfer takes two cycles at the cost of one extra register.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `RST_PRDATA;
    end else if (rd_setup) begin
      prdata <= next_prdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file. The execution logic wins over a same-cycle APB write,
  // since the core owns these registers while it runs. Each register has
  // its own process so that the priority of one cannot leak into another.

  // The counter restarts just under the top of memory, where the reset
  // vector sits.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      program_counter <= `RST_PROGRAM_COUNTER; // RQ9
    end else if (core_pc_we) begin
      program_counter <= core_pc_d; // RQ1
    end else if (wr_acc && is_ofs(paddr, `OFS_PROGRAM_COUNTER)) begin
      program_counter <= strobe16(program_counter, pwdata, pstrb);
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accumulator <= `RST_ZERO16;
    end else if (core_acc_we) begin
      accumulator <= merge16(accumulator, core_acc_d, core_op8); // RQ2
    end else if (wr_acc && is_ofs(paddr, `OFS_ACCUMULATOR)) begin
      accumulator <= strobe16(accumulator, pwdata, pstrb);
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      temp_accumulator <= `RST_ZERO16;
    end else if (core_tmp_we) begin
      temp_accumulator <= merge16(temp_accumulator, core_tmp_d,
                                  core_op8); // RQ3
    end else if (wr_acc && is_ofs(paddr, `OFS_TEMP_ACC)) begin
      temp_accumulator <= strobe16(temp_accumulator, pwdata, pstrb);
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      index_register <= `RST_ZERO16;
    end else if (core_ix_we) begin
      index_register <= core_ix_d; // RQ4
    end else if (wr_acc && is_ofs(paddr, `OFS_INDEX_REGISTER)) begin
      index_register <= strobe16(index_register, pwdata, pstrb);
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      extra_pointer <= `RST_ZERO16;
    end else if (core_ep_we) begin
      extra_pointer <= core_ep_d; // RQ5
    end else if (wr_acc && is_ofs(paddr, `OFS_EXTRA_POINTER)) begin
      extra_pointer <= strobe16(extra_pointer, pwdata, pstrb);
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_pointer <= `RST_ZERO16;
    end else if (core_sp_we) begin
      stack_pointer <= core_sp_d; // RQ6
    end else if (wr_acc && is_ofs(paddr, `OFS_STACK_POINTER)) begin
      stack_pointer <= strobe16(stack_pointer, pwdata, pstrb);
    end
  end

  // Software may move the program base, but it must stay below the
  // vector tables or the reset vector stops decoding as program.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_base <= PROG_BASE;
    end else if (wr_acc && is_ofs(paddr, `OFS_PROGRAM_BASE)) begin
      prog_base <= strobe16(prog_base, pwdata, pstrb);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program status is two byte registers so neither write disturbs the other.

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rp_byte <= `RST_RP;
    end else if (core_rp_we) begin
      rp_byte <= core_rp_d; // RQ12
    end else if (wr_acc && pstrb[1] &&
                 is_ofs(paddr, `OFS_PROGRAM_STATUS)) begin
      rp_byte <= pwdata[15:8]; // RQ12
    end
  end

  // The condition code byte carries the interrupt enable and level fields.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ccr_byte <= `RST_CCR; // RQ9
    end else if (core_ccr_we) begin
      ccr_byte <= core_ccr_d; // RQ12
    end else if (wr_acc && pstrb[0] &&
                 is_ofs(paddr, `OFS_PROGRAM_STATUS)) begin
      ccr_byte <= pwdata[7:0]; // RQ12
    end
  end

  assign program_status        = {rp_byte, ccr_byte}; // RQ7 RQ8
  assign register_bank_pointer = rp_byte; // RQ8
  assign condition_code_byte   = ccr_byte; // RQ8
  // Interrupt enable and level are fixed fields of the condition code byte.
  assign irq_enable            = ccr_byte[`CCR_IRQ_ENABLE_BIT];
  assign interrupt_level       = ccr_byte[`CCR_LEVEL_HI:`CCR_LEVEL_LO];

  // 8-bit instructions see only the low bytes as operands.
  assign acc_operand = core_op8 ? {8'h00, accumulator[7:0]}
                                : accumulator; // RQ2
  assign tmp_operand = core_op8 ? {8'h00, temp_accumulator[7:0]}
                                : temp_accumulator; // RQ3

  ////////////////////////////////////////////////////////////////////////////
  // Address decode. Addresses between data and program areas select nothing;
  // the vector tables are expected just under the top of the program area,
  // so the base must stay below them. RQ11

  assign sel_io      = (core_addr <= IO_LAST); // RQ10
  assign sel_data    = (core_addr > IO_LAST) &&
                       (core_addr <= DATA_LAST); // RQ10
  assign sel_program = (core_addr >= prog_base) &&
                       (core_addr > DATA_LAST); // RQ10
  assign sel_none    = ~(sel_io | sel_data | sel_program);

  // The region register lags the decode by one cycle, so software sees
  // where the core pointed on the previous edge.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      region <= `REGION_NONE;
    end else if (sel_io) begin
      region <= `REGION_IO;
    end else if (sel_data) begin
      region <= `REGION_DATA;
    end else if (sel_program) begin
      region <= `REGION_PROGRAM;
    end else begin
      region <= `REGION_NONE;
    end
  end

endmodule

// >>> tb/cpu_regs_sva.sv
`timescale 1ns/1ns
module cpu_regs_chk #(
  parameter [15:0] IO_LAST   = 16'h007F,
  parameter [15:0] DATA_LAST = 16'h027F,
  parameter [15:0] PROG_BASE = 16'h8000
) (
  // Clock, reset and bus.
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  // Execution logic side.
  input wire        core_op8,
  input wire        core_pc_we,
  input wire [15:0] core_pc_d,
  input wire        core_acc_we,
  input wire [15:0] core_acc_d,
  input wire        core_rp_we,
  input wire        core_ccr_we,
  input wire [15:0] program_counter,
  input wire [15:0] accumulator,
  input wire [15:0] acc_operand,
  input wire [15:0] program_status,
  input wire [7:0]  register_bank_pointer,
  input wire [7:0]  condition_code_byte,
  input wire        irq_enable,
  input wire [1:0]  interrupt_level,
  // Decode.
  input wire [15:0] core_addr,
  input wire        sel_io,
  input wire        sel_data,
  input wire        sel_program,
  input wire        sel_none
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_pc_reset: assert property ($rose(presetn) |-> program_counter ==
    16'hFFFD && !irq_enable && interrupt_level == 2'h3)
    else $error("reset state wrong");
  a_pc_load: assert property (core_pc_we |=>
    program_counter == $past(core_pc_d)) else $error("pc load lost");
  a_acc_narrow: assert property (core_acc_we && core_op8 |=>
    accumulator == {$past(accumulator[15:8]), $past(core_acc_d[7:0])})
    else $error("narrow write touched high byte");
  a_acc_operand: assert property (acc_operand == (core_op8 ?
    {8'h00, accumulator[7:0]} : accumulator)) else $error("operand width");
  a_status_pack: assert property (program_status ==
    {register_bank_pointer, condition_code_byte}) else $error("status split");
  a_byte_indep: assert property (core_ccr_we && !core_rp_we && !psel |=>
    $stable(register_bank_pointer)) else $error("bank pointer disturbed");
  a_region_onehot: assert property ($onehot({sel_io, sel_data,
    sel_program, sel_none})) else $error("region not one-hot");
  a_io_low: assert property (core_addr <= IO_LAST |-> sel_io)
    else $error("io region missed");
  a_prog_high: assert property (core_addr >= PROG_BASE &&
    core_addr > DATA_LAST |-> sel_program) else $error("program missed");
  c_narrow: cover property (core_acc_we && core_op8);
  c_reset: cover property ($rose(presetn));
  c_prog: cover property (sel_program);
endmodule
////////////////////////////////////////////////////////////////////////////
bind cpu_dedicated_registers cpu_regs_chk #(.IO_LAST(IO_LAST),
  .DATA_LAST(DATA_LAST), .PROG_BASE(PROG_BASE)) chk_u (.*);

// >>> tb/cpu_dedicated_registers_bench.sv
`timescale 1ns/1ns
module cpu_dedicated_registers_bench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, op8 = 0;
  logic [7:0] paddr = 0, we = 0, a;
  logic [31:0] pwdata = 0, rd, r;
  logic [3:0] pstrb = 0;
  logic pready, pslverr, err, irqe;
  logic [15:0] d [0:7], m [0:7], addr = 0;
  wire [31:0] prdata;
  wire [15:0] q [0:5], ps, aop, top;
  wire [3:0] sel;
  wire [7:0] rbp, ccb;
  wire [1:0] ilvl;
  integer seed = 32'h59974431, err_total = 0, n_checks = 0, i, k, j, c;
  initial forever #10 pclk = ~pclk;
  cpu_dedicated_registers dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .core_op8(op8), .core_pc_we(we[0]),
    .core_pc_d(d[0]), .core_acc_we(we[1]), .core_acc_d(d[1]),
    .core_tmp_we(we[2]), .core_tmp_d(d[2]), .core_ix_we(we[3]),
    .core_ix_d(d[3]), .core_ep_we(we[4]), .core_ep_d(d[4]),
    .core_sp_we(we[5]), .core_sp_d(d[5]), .core_rp_we(we[6]),
    .core_rp_d(d[6][7:0]), .core_ccr_we(we[7]), .core_ccr_d(d[7][7:0]),
    .program_counter(q[0]), .accumulator(q[1]), .temp_accumulator(q[2]),
    .index_register(q[3]), .extra_pointer(q[4]), .stack_pointer(q[5]),
    .program_status(ps), .register_bank_pointer(rbp),
    .condition_code_byte(ccb), .irq_enable(irqe), .interrupt_level(ilvl),
    .acc_operand(aop), .tmp_operand(top), .core_addr(addr),
    .sel_io(sel[0]), .sel_data(sel[1]), .sel_program(sel[2]),
    .sel_none(sel[3]));
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // One idle edge before each setup keeps every signal to one change a step.
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] wd,
           input logic [3:0] s);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  function logic [3:0] zone(input logic [15:0] ad);
    zone = ad <= 16'h007F ? 4'h1 : ad <= 16'h027F ? 4'h2 :
           ad >= 16'h8000 ? 4'h4 : 4'h8;
  endfunction
  function logic [31:0] ex(input logic [7:0] ad);
    ex = ad == 8'h18 ? {m[6][7:0], m[7][7:0]} : ad < 8'h18 ? m[ad >> 2] :
         ad == 8'h1C ? 16'h8000 : ad == 8'h20 ? zone(addr) : 0;
  endfunction
  //////////////////////////////////////////////////////////////////////////
  always @(posedge pclk or negedge presetn)
    if (!presetn) begin
      for (j = 0; j < 8; j++)
        m[j] <= j == 0 ? 16'hFFFD : j == 7 ? 16'h000C : 16'h0000;
    end else begin
      for (j = 0; j < 8; j++)
        if (we[j])
          m[j] <= (j inside {1, 2} && op8) ? {m[j][15:8], d[j][7:0]} : d[j];
      j = paddr >> 2;
      if (psel && penable && pwrite && paddr[1:0] == 0 && j < 7) begin
        if (j < 6) begin
          if (!we[j])
            m[j] <= {pstrb[1] ? pwdata[15:8] : m[j][15:8],
                     pstrb[0] ? pwdata[7:0] : m[j][7:0]};
        end else begin
          if (pstrb[1] && !we[6]) m[6] <= pwdata[15:8];
          if (pstrb[0] && !we[7]) m[7] <= pwdata[7:0];
        end
      end
    end
  always @(negedge pclk) if (presetn) begin
    for (c = 0; c < 6; c++) chk(q[c], m[c]);
    chk(ps, {m[6][7:0], m[7][7:0]});
    chk({rbp, ccb}, {m[6][7:0], m[7][7:0]});
    chk({irqe, ilvl}, m[7][4:2]);
    chk(aop, op8 ? m[1][7:0] : m[1]);
    chk(top, op8 ? m[2][7:0] : m[2]);
    chk(sel, zone(addr));
  end
  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    wrap_up;
  end
  initial begin
    for (i = 0; i < 8; i++) d[i] = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1;
    addr <= 16'hFFFD;
    @(negedge pclk);
    chk(sel[2], 1'b1);
    for (i = 0; i < 3000; i++) begin
      @(posedge pclk);
      if (i == 1500) presetn <= 0;
      if (i == 1503) presetn <= 1;
      r = $random(seed);
      we <= $random(seed);
      op8 <= r[31];
      addr <= r[15:0] >> r[19:16];
      for (k = 0; k < 8; k++) d[k] <= $random(seed);
    end
    @(posedge pclk);
    we <= 0;
    op8 <= 0;
    for (i = 0; i < 200; i++) begin
      r = $random(seed);
      a = r[2:0] == 7 ? (r[3] ? 8'h24 : r[8] ? 8'h20 : 8'h1C) :
          {3'h0, r[2:0], 2'h0};
      apb(1, a, $random(seed), a == 8'h1C ? 4'h0 : r[7:4]);
      chk(err, a == 8'h24);
      apb(0, a, 0, 0);
      chk(rd, ex(a));
    end
    wrap_up;
  end
endmodule
